// ==== logic/rsm_pkg.sv ====
// constants and types of the reset source manager
package rsm_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int LPO_HZ = 1000;
	localparam int LPO_DIV = CLK_HZ / LPO_HZ;
	localparam int PIN_DRIVE_MIN = 128;
	localparam int STOP_ACK_LPO = 1025;
	localparam int LPO_FILT_CNT = 3;
	localparam int LPO_SYNC_CYC = 2;
	localparam logic [31:0] BOOT_SP_OFS = 32'h0000_0000;
	localparam logic [31:0] BOOT_PC_OFS = 32'h0000_0004;
	localparam logic [31:0] BOOT_LR = 32'hffff_ffff;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_STS_LO = 8'h00;
	localparam logic [7:0] OFS_STS_HI = 8'h04;
	localparam logic [7:0] OFS_PFC = 8'h08;
	localparam logic [7:0] OFS_PFW = 8'h0c;
	localparam logic [7:0] OFS_LVC = 8'h10;
	localparam logic [7:0] OFS_CMON = 8'h14;
	localparam logic [7:0] OFS_WEN = 8'h18;
	localparam logic [7:0] OFS_WFLG = 8'h1c;
	localparam int LO_WAKE = 0;
	localparam int LO_LVD = 1;
	localparam int LO_LOC = 2;
	localparam int LO_WATCHDOG_CAUSE = 5;
	localparam int LO_PIN = 6;
	localparam int LO_POR = 7;
	localparam int HI_LOCKUP = 1;
	localparam int HI_SW = 2;
	localparam int HI_DBG = 3;
	localparam int HI_SACK = 5;
	localparam logic [7:0] STS_LO_RST = 8'h82;
	localparam int PFC_W = 3;
	localparam int PFC_STOP = 2;
	localparam logic [1:0] FSEL_BUS = 2'h1;
	localparam logic [1:0] FSEL_LPO = 2'h2;
	localparam int PFW_W = 5;
	localparam int LVC_RE = 4;
	localparam int LVC_TH_W = 2;
	localparam logic [7:0] LVC_RST = 8'h10;
	localparam logic [7:0] LVC_MASK = 8'h13;
	localparam int CME_BIT = 0;
	localparam int HT_ACT = 1;
	typedef enum logic [3:0] {
		PM_HSRUN, PM_RUN, PM_WAIT, PM_STOP, PM_VLPR, PM_VLPW, PM_VLPS,
		PM_LLS, PM_VLLS, PM_DEEPEST_LEAKAGE_STOP
	} rsm_pm_t;
	typedef enum logic [1:0] {SQ_RUN, SQ_HOLD, SQ_FLASH, SQ_REL} rsm_seq_t;
	typedef enum logic [1:0] {FM_BYPASS, FM_BUS, FM_LPO} rsm_fm_t;
	typedef struct packed {
		logic por_only_n;
		logic chip_por_nvlls_n;
		logic chip_por_n;
		logic chip_rst_nvlls_n;
		logic early_chip_n;
		logic chip_n;
		logic core_n;
	} rsm_rst_t;
	typedef struct packed {
		logic tdi_pu;
		logic tms_pu;
		logic tck_pd;
		logic tdo_pull;
	} rsm_jtag_t;
	typedef struct packed {
		logic [31:0] sp_ofs;
		logic [31:0] pc_ofs;
		logic [31:0] lr;
	} rsm_boot_t;
	typedef struct packed {
		logic pin;
		logic low_voltage_detect;
		logic loc;
	} rsm_async_t;
	typedef struct packed {
		logic watchdog_cause;
		logic lockup;
		logic sw;
		logic dbg;
		logic core_hold;
		logic stop_req;
		logic stop_ack;
	} rsm_src_t;
	localparam rsm_jtag_t JTAG_PULLS = '{1'b1, 1'b1, 1'b1, 1'b0};
	localparam rsm_boot_t BOOT_VEC = '{BOOT_SP_OFS, BOOT_PC_OFS, BOOT_LR};
endpackage

// ==== logic/rsm_reset_source_manager.sv ====
// reset source manager: causes, pin filter, reset tiers, bus slave
`timescale 1ns/1ps
module rsm_reset_source_manager
	import rsm_pkg::*;
#(
	parameter int LPO_DIV_P = LPO_DIV,
	parameter int WAKE_N = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire rsm_pm_t pm_mode,
	input wire logic reset_pin,
	output logic reset_pin_low,
	output logic reset_pin_en,
	input wire logic lvd_low,
	input wire logic clk_lost,
	input wire rsm_src_t srcs,
	input wire logic [WAKE_N-1:0] wake_in,
	input wire logic flash_done,
	output rsm_rst_t tiers,
	output rsm_jtag_t jtag_pull,
	output rsm_boot_t boot,
	output logic periph_off,
	output logic pins_default,
	output logic lvd_en,
	output logic [LVC_TH_W-1:0] lvd_thresh
);
	localparam int DW = $clog2(LPO_DIV_P);
	localparam int SW = $clog2(STOP_ACK_LPO + 1);
	localparam int CW = $clog2(PIN_DRIVE_MIN + 1);
	localparam logic [SW-1:0] SACK_MAX = SW'(STOP_ACK_LPO);
	localparam logic [CW-1:0] PIN_MAX = CW'(PIN_DRIVE_MIN);
	localparam logic [1:0] LCNT_END = 2'(LPO_FILT_CNT - 1);

	typedef struct packed {
		rsm_async_t s1;
		rsm_async_t s2;
		logic [DW-1:0] div;
		logic filt;
		logic [PFW_W-1:0] fcnt;
		logic [LPO_SYNC_CYC-1:0] lsync;
		logic [1:0] lcnt;
		logic [SW-1:0] sack;
		rsm_seq_t seq;
		logic [CW-1:0] cnt;
		logic nopin;
		logic t_lvd;
		logic t_wk;
		logic [7:0] sts_lo;
		logic [7:0] sts_hi;
		logic [PFC_W-1:0] pfc;
		logic [PFW_W-1:0] pfw;
		logic [7:0] lvc;
		logic clock_monitor_enable;
		logic [WAKE_N-1:0] wen;
		logic [WAKE_N-1:0] wflg;
		logic wr_pend;
		logic [ADDR_W-1:0] wa;
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
		rsm_rst_t rst;
		rsm_jtag_t jtag;
		rsm_boot_t boot;
		logic periph_off;
		logic pins_default;
		logic lvd_en;
		logic pin_en;
	} rsm_st_t;

	rsm_st_t q;
	rsm_st_t d;
	logic lpo_tick;
	logic stopish;
	rsm_fm_t fm;
	logic pin_src;
	logic lvd_src;
	logic loc_src;
	logic wake_src;
	logic sack_src;
	logic any_src;
	logic oth;
	logic inr;
	logic ap;
	logic [7:0] cause_lo;
	logic [7:0] cause_hi;
	logic [WAKE_N-1:0] wclr;
	logic [WAKE_N-1:0] wset;

	always_comb begin
		d = q;
		d.s1 = {reset_pin, lvd_low, clk_lost};
		d.s2 = q.s1;
		// slow oscillator tick from the bus clock
		lpo_tick = (q.div == DW'(LPO_DIV_P - 1));
		d.div = lpo_tick ? '0 : q.div + 1'b1;

		// filter clock choice per power mode
		stopish = pm_mode inside {PM_STOP, PM_VLPS, PM_LLS, PM_VLLS};
		if (pm_mode == PM_DEEPEST_LEAKAGE_STOP) begin
			fm = FM_BYPASS;
		end else if (stopish) begin
			fm = q.pfc[PFC_STOP] ? FM_LPO : FM_BYPASS;
		end else begin
			case (q.pfc[1:0])
			FSEL_BUS: fm = FM_BUS;
			FSEL_LPO: fm = FM_LPO;
			default: fm = FM_BYPASS;
			endcase
		end
		case (fm)
		FM_BUS: begin
			// output follows after width+1 stable cycles
			if (q.s2.pin == q.filt) begin
				d.fcnt = '0;
			end else if (q.fcnt == q.pfw) begin
				d.filt = q.s2.pin;
				d.fcnt = '0;
			end else begin
				d.fcnt = q.fcnt + 1'b1;
			end
		end
		FM_LPO: begin
			if (lpo_tick) begin
				d.lsync = {q.lsync[LPO_SYNC_CYC-2:0], q.s2.pin};
				if (q.lsync[LPO_SYNC_CYC-1] == q.filt) begin
					d.lcnt = '0;
				end else if (q.lcnt == LCNT_END) begin
					d.filt = q.lsync[LPO_SYNC_CYC-1];
					d.lcnt = '0;
				end else begin
					d.lcnt = q.lcnt + 1'b1;
				end
			end
		end
		default: begin
			d.filt = q.s2.pin;
			d.fcnt = '0;
			d.lcnt = '0;
			d.lsync = {LPO_SYNC_CYC{q.s2.pin}};
		end
		endcase

		// reset sources
		pin_src = !q.filt && q.seq == SQ_RUN;
		d.lvd_en = pm_mode inside {PM_HSRUN, PM_RUN, PM_WAIT, PM_STOP};
		lvd_src = q.lvd_en && q.lvc[LVC_RE] && q.s2.low_voltage_detect;
		loc_src = q.clock_monitor_enable && q.s2.loc;
		wake_src = pm_mode inside {PM_VLLS, PM_DEEPEST_LEAKAGE_STOP} && |(wake_in & q.wen);
		if (srcs.stop_req && !srcs.stop_ack) begin
			if (lpo_tick && q.sack != SACK_MAX) begin
				d.sack = q.sack + 1'b1;
			end
		end else begin
			d.sack = '0;
		end
		sack_src = srcs.stop_req && !srcs.stop_ack && q.sack == SACK_MAX;
		cause_lo = '0;
		cause_hi = '0;
		cause_lo[LO_LVD] = lvd_src;
		cause_lo[LO_LOC] = loc_src;
		cause_lo[LO_WATCHDOG_CAUSE] = srcs.watchdog_cause;
		cause_lo[LO_PIN] = pin_src;
		cause_hi[HI_LOCKUP] = srcs.lockup;
		cause_hi[HI_SW] = srcs.sw;
		cause_hi[HI_DBG] = srcs.dbg;
		cause_hi[HI_SACK] = sack_src;
		oth = |{cause_lo, cause_hi};
		cause_lo[LO_WAKE] = wake_src;
		any_src = oth || wake_src;

		// reset sequence
		case (q.seq)
		SQ_RUN: begin
			if (any_src) begin
				d.seq = SQ_HOLD;
				d.cnt = '0;
				d.sts_lo = cause_lo;
				d.sts_hi = cause_hi;
				d.nopin = !oth;
				d.t_lvd = lvd_src;
				d.t_wk = wake_src;
			end
		end
		SQ_HOLD: begin
			if (!any_src) begin
				d.seq = SQ_FLASH;
			end
		end
		SQ_FLASH: begin
			if (any_src) begin
				d.seq = SQ_HOLD;
			end else if (q.cnt == PIN_MAX && flash_done) begin
				d.seq = SQ_REL;
			end
		end
		SQ_REL: begin
			if (any_src) begin
				d.seq = SQ_HOLD;
				d.cnt = '0;
			end else if (q.filt || q.nopin) begin
				d.seq = SQ_RUN;
			end
		end
		default: d.seq = SQ_RUN;
		endcase
		if (q.seq != SQ_RUN) begin
			d.sts_lo = q.sts_lo | cause_lo;
			d.sts_hi = q.sts_hi | cause_hi;
			d.nopin = q.nopin && !oth;
			d.t_lvd = q.t_lvd || lvd_src;
			d.t_wk = q.t_wk || wake_src;
			if (q.cnt != PIN_MAX && !(q.seq == SQ_REL && any_src)) begin
				d.cnt = q.cnt + 1'b1;
			end
		end

		// tier outputs
		inr = d.seq != SQ_RUN;
		d.rst.por_only_n = 1'b1;
		d.rst.chip_por_nvlls_n = !(inr && d.t_lvd);
		d.rst.chip_por_n = !(inr && (d.t_lvd || d.t_wk));
		d.rst.chip_rst_nvlls_n = !(inr && !d.nopin);
		d.rst.early_chip_n = d.seq != SQ_HOLD;
		d.rst.chip_n = !inr;
		d.rst.core_n = !inr && !srcs.core_hold;
		d.pin_en = d.seq inside {SQ_HOLD, SQ_FLASH} && !d.nopin;
		d.periph_off = inr;
		d.pins_default = inr;
		d.jtag = JTAG_PULLS;
		d.boot = BOOT_VEC;

		// register writes in the data phase
		wclr = '0;
		if (q.wr_pend) begin
			case (q.wa)
			OFS_PFC: d.pfc = hwdata[PFC_W-1:0];
			OFS_PFW: d.pfw = hwdata[PFW_W-1:0];
			OFS_LVC: d.lvc = hwdata[7:0] & LVC_MASK;
			OFS_CMON: d.clock_monitor_enable = hwdata[CME_BIT];
			OFS_WEN: d.wen = hwdata[WAKE_N-1:0];
			OFS_WFLG: wclr = hwdata[WAKE_N-1:0];
			default: ;
			endcase
		end
		// a wakeup in the clearing cycle stays set
		wset = (pm_mode inside {PM_LLS, PM_VLLS, PM_DEEPEST_LEAKAGE_STOP}) ?
			(wake_in & q.wen) : '0;
		d.wflg = (q.wflg & ~wclr) | wset;

		// address phase; reads see this cycle's write
		ap = hsel && htrans[HT_ACT] && hready;
		d.wr_pend = ap && hwrite;
		d.wa = haddr[ADDR_W-1:0];
		d.hrdata = '0;
		if (ap && !hwrite) begin
			case (haddr[ADDR_W-1:0])
			OFS_STS_LO: d.hrdata = 32'(d.sts_lo);
			OFS_STS_HI: d.hrdata = 32'(d.sts_hi);
			OFS_PFC: d.hrdata = 32'(d.pfc);
			OFS_PFW: d.hrdata = 32'(d.pfw);
			OFS_LVC: d.hrdata = 32'(d.lvc);
			OFS_CMON: d.hrdata = 32'(d.clock_monitor_enable);
			OFS_WEN: d.hrdata = 32'(d.wen);
			OFS_WFLG: d.hrdata = 32'(d.wflg);
			default: d.hrdata = '0;
			endcase
		end
		d.hreadyout = 1'b1;
		d.hresp = 1'b0;
	end

	// all state is loaded with its reset values only by chip power-on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.s1 <= '{1'b1, 1'b0, 1'b0};
			q.s2 <= '{1'b1, 1'b0, 1'b0};
			q.filt <= 1'b1;
			q.lsync <= '1;
			q.seq <= SQ_HOLD;
			q.t_lvd <= 1'b1;
			q.sts_lo <= STS_LO_RST;
			q.lvc <= LVC_RST;
			q.hreadyout <= 1'b1;
			q.jtag <= JTAG_PULLS;
			q.boot <= BOOT_VEC;
			q.periph_off <= 1'b1;
			q.pins_default <= 1'b1;
			q.lvd_en <= 1'b1;
			q.pin_en <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign hreadyout = q.hreadyout;
	assign hresp = q.hresp;
	assign hrdata = q.hrdata;
	assign reset_pin_low = 1'b0;
	assign reset_pin_en = q.pin_en;
	assign tiers = q.rst;
	assign jtag_pull = q.jtag;
	assign boot = q.boot;
	assign periph_off = q.periph_off;
	assign pins_default = q.pins_default;
	assign lvd_en = q.lvd_en;
	assign lvd_thresh = q.lvc[LVC_TH_W-1:0];

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	AST_POR_LVD: assert property (
		q.sts_lo[LO_POR] |-> q.sts_lo[LO_LVD])
		else $error("power-on flag without low-voltage flag");
	AST_LVD_OFF: assert property (
		pm_mode inside {PM_VLPR, PM_VLPW, PM_VLPS, PM_LLS} |=> !q.lvd_en)
		else $error("low-voltage detect left on in low-power mode");
	AST_LVD_RST: assert property (
		lvd_src |=> q.seq == SQ_HOLD && q.sts_lo[LO_LVD]
			&& !q.rst.chip_por_nvlls_n)
		else $error("low supply did not hold reset");
	AST_WATCHDOG_CAUSE: assert property (
		srcs.watchdog_cause |=> q.sts_lo[LO_WATCHDOG_CAUSE] && !q.rst.chip_n)
		else $error("watchdog reset missing");
	AST_SW: assert property (
		srcs.sw |=> q.sts_hi[HI_SW] && !q.rst.chip_n)
		else $error("software reset missing");
	AST_LOCKUP: assert property (
		srcs.lockup |=> q.sts_hi[HI_LOCKUP] && !q.rst.core_n)
		else $error("lockup reset missing");
	AST_CORE_HOLD: assert property (
		srcs.core_hold |=> !q.rst.core_n)
		else $error("core left reset under hold");
	AST_SACK: assert property (
		sack_src |=> q.sts_hi[HI_SACK] && q.seq == SQ_HOLD)
		else $error("stop acknowledge timeout did not reset");
	AST_PIN_MIN: assert property (
		$fell(q.pin_en) |-> q.cnt == PIN_MAX && $past(flash_done))
		else $error("reset pin released too early");
	AST_CHIP_REL: assert property (
		$rose(q.rst.chip_n) |-> $past(q.filt) || $past(q.nopin))
		else $error("chip reset released with pin low");
	AST_TIER: assert property (
		!q.rst.chip_por_nvlls_n |-> !q.rst.chip_por_n
			&& !q.rst.chip_rst_nvlls_n && !q.rst.chip_n)
		else $error("lower tiers not asserted");
	AST_DEEP: assert property (
		pm_mode == PM_DEEPEST_LEAKAGE_STOP |=> q.filt == $past(q.s2.pin))
		else $error("filter not bypassed in deepest stop");
endmodule

// ==== verif/rsm_pad_model.sv ====
// reset pin pad with pull-up and flash init model
`timescale 1ns/1ps
module rsm_pad_model #(
	parameter int FLASH_CYC = 20
) (
	input wire logic hclk,
	input wire logic reset_pin_en,
	input wire logic reset_pin_low,
	input wire logic early_chip_n,
	input wire logic ext_hold,
	output logic reset_pin,
	output logic flash_done
);
	int cnt = 0;
	// open drain: low while any party pulls, else pull-up
	assign reset_pin = (reset_pin_en && !reset_pin_low) || ext_hold ? 1'b0 : 1'b1;
	// flash init starts once early chip reset lets go
	always @(posedge hclk) begin
		if (early_chip_n !== 1'b1)
			cnt <= 0;
		else if (cnt < FLASH_CYC)
			cnt <= cnt + 1;
	end
	assign flash_done = cnt >= FLASH_CYC;
endmodule

// ==== verif/testbench.sv ====
// self-checking bench of the reset source manager
`timescale 1ns/1ps
module testbench;
	import rsm_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans, lvd_thresh;
	logic [2:0] hsize;
	rsm_pm_t pm_mode;
	logic reset_pin, reset_pin_low, reset_pin_en, lvd_low, clk_lost;
	rsm_src_t srcs;
	logic [7:0] wake_in;
	logic flash_done, periph_off, pins_default, lvd_en, ext_hold;
	rsm_rst_t tiers;
	rsm_jtag_t jtag_pull;
	rsm_boot_t boot;
	int fails = 0;
	int n_tests = 0;
	int pe, h, th;
	int run = 0;
	logic [7:0] wm;
	localparam int DIV = 4;
	rsm_reset_source_manager #(.LPO_DIV_P(DIV), .WAKE_N(8))
		rsm_reset_source_manager_i (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.pm_mode(pm_mode), .reset_pin(reset_pin),
		.reset_pin_low(reset_pin_low), .reset_pin_en(reset_pin_en),
		.lvd_low(lvd_low), .clk_lost(clk_lost), .srcs(srcs),
		.wake_in(wake_in), .flash_done(flash_done), .tiers(tiers),
		.jtag_pull(jtag_pull), .boot(boot), .periph_off(periph_off),
		.pins_default(pins_default), .lvd_en(lvd_en),
		.lvd_thresh(lvd_thresh));
	rsm_pad_model rsm_pad_model_i (.hclk(hclk), .reset_pin_en(reset_pin_en),
		.reset_pin_low(reset_pin_low), .early_chip_n(tiers.early_chip_n),
		.ext_hold(ext_hold), .reset_pin(reset_pin),
		.flash_done(flash_done));
	// length of the last stretch in which the block drove the pin
	always @(posedge hclk) begin
		if (reset_pin_en === 1'b1) begin
			run <= run + 1;
		end else if (run != 0) begin
			pe <= run;
			run <= 0;
		end
	end
	task automatic summarize();
		$display("tests=%0d fails=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [95:0] g, input logic [95:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(96'(q), 96'(e));
		chk(96'({hresp, reset_pin_low}), 96'h0);
	endtask
	// expected {status_high, status_low} per reset source
	function automatic logic [15:0] st(input int k);
		case (k)
			0: st = 16'h0020;
			1: st = 16'h0200;
			2: st = 16'h0400;
			3: st = 16'h0800;
			4: st = 16'h0002;
			5: st = 16'h0004;
			6: st = 16'h0040;
			8: st = 16'h0001;
			default: st = 16'h2000;
		endcase
	endfunction
	task automatic chkst(input int k);
		logic [15:0] e;
		e = st(k);
		rd(OFS_STS_LO, {24'h0, e[7:0]});
		rd(OFS_STS_HI, {24'h0, e[15:8]});
	endtask
	task automatic wlo(input int lim);
		int i;
		i = 0;
		while (tiers.chip_n !== 1'b0 && i < lim) begin
			@(posedge hclk);
			i++;
		end
		chk(96'(tiers.chip_n), 96'h0);
	endtask
	task automatic wrel();
		int i;
		i = 0;
		while (tiers.chip_n !== 1'b1 && i < 3000) begin
			@(posedge hclk);
			i++;
		end
		chk(96'(tiers.chip_n), 96'h1);
	endtask
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	initial begin
		repeat (60000) @(posedge hclk);
		fails++;
		summarize();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		pm_mode = PM_RUN;
		lvd_low = 1'b0;
		clk_lost = 1'b0;
		srcs = 7'h01;
		wake_in = 8'h00;
		ext_hold = 1'b0;
		void'($urandom(78));
		repeat (10) @(posedge hclk);
		chk(96'(tiers), 96'h0);
		chk(boot, {32'h0, 32'h4, 32'hffff_ffff});
		chk(96'(jtag_pull), 96'he);
		chk(96'({periph_off, pins_default}), 96'h3);
		hresetn <= 1'b1;
		@(posedge hclk);
		wrel();
		chk(96'(pe >= 128), 96'h1);
		chk(96'({periph_off, pins_default}), 96'h0);
		rd(OFS_STS_LO, 32'h82);
		rd(OFS_STS_HI, 32'h0);
		rd(OFS_PFC, 32'h0);
		rd(OFS_PFW, 32'h0);
		rd(OFS_LVC, 32'h10);
		rd(OFS_CMON, 32'h0);
		rd(8'h20, 32'h0);
		bus(1'b1, OFS_STS_LO, 32'hff);
		rd(OFS_STS_LO, 32'h82);
		th = $urandom_range(3, 0);
		bus(1'b1, OFS_LVC, 32'h10 | th);
		rd(OFS_LVC, 32'h10 | th);
		chk(96'(lvd_thresh), 96'(th));
		bus(1'b1, OFS_CMON, 32'h1);
		$display("test registers done");
		for (int m = 0; m < 10; m++) begin
			pm_mode <= rsm_pm_t'(m);
			repeat (2) @(posedge hclk);
			chk(96'(lvd_en), 96'(m <= 3));
		end
		pm_mode <= PM_RUN;
		$display("test modes done");
		for (int k = 0; k < 6; k++) begin
			h = $urandom_range(8, 1);
			srcs <= {k == 0, k == 1, k == 2, k == 3, k == 3, 2'b01};
			lvd_low <= k == 4;
			clk_lost <= k == 5;
			wlo(10);
			repeat (h) @(posedge hclk);
			chk(96'(tiers.chip_n), 96'h0);
			srcs <= {4'h0, k == 3, 2'b01};
			lvd_low <= 1'b0;
			clk_lost <= 1'b0;
			wrel();
			chk(96'(pe >= 128), 96'h1);
			chk(96'(tiers.core_n), 96'(k != 3));
			srcs <= 7'h01;
			chkst(k);
			chk(96'(tiers.core_n), 96'h1);
		end
		$display("test sources done");
		h = $urandom_range(6, 2);
		bus(1'b1, OFS_PFC, {30'h0, FSEL_BUS});
		bus(1'b1, OFS_PFW, 32'(h));
		ext_hold <= 1'b1;
		repeat (h) @(posedge hclk);
		ext_hold <= 1'b0;
		repeat (20) @(posedge hclk);
		chk(96'(tiers.chip_n), 96'h1);
		ext_hold <= 1'b1;
		wlo(30);
		repeat (300) @(posedge hclk);
		chk(96'({tiers.chip_n, reset_pin_en}), 96'h0);
		ext_hold <= 1'b0;
		wrel();
		chkst(6);
		$display("test pin done");
		// slow filter in stop: short pulse ignored, long hold resets
		bus(1'b1, OFS_PFC, 32'h4);
		pm_mode <= PM_STOP;
		ext_hold <= 1'b1;
		repeat (2 * DIV) @(posedge hclk);
		ext_hold <= 1'b0;
		repeat (10 * DIV) @(posedge hclk);
		chk(96'(tiers.chip_n), 96'h1);
		ext_hold <= 1'b1;
		wlo((LPO_SYNC_CYC + LPO_FILT_CNT + 2) * DIV);
		repeat (DIV) @(posedge hclk);
		ext_hold <= 1'b0;
		wrel();
		chkst(6);
		// deepest stop bypasses even with slow stop filter chosen
		pm_mode <= PM_DEEPEST_LEAKAGE_STOP;
		repeat (2) @(posedge hclk);
		ext_hold <= 1'b1;
		repeat (2) @(posedge hclk);
		ext_hold <= 1'b0;
		wlo(6);
		wrel();
		chkst(6);
		$display("test filters done");
		wm = 8'h1 << $urandom_range(7, 0);
		bus(1'b1, OFS_WEN, 32'(wm));
		pm_mode <= PM_LLS;
		wake_in <= wm;
		repeat (4) @(posedge hclk);
		wake_in <= 8'h00;
		chk(96'(tiers.chip_n), 96'h1);
		rd(OFS_WFLG, 32'(wm));
		bus(1'b1, OFS_WFLG, 32'(wm));
		rd(OFS_WFLG, 32'h0);
		pm_mode <= PM_VLLS;
		wake_in <= ~wm;
		repeat (4) @(posedge hclk);
		chk(96'(tiers.chip_n), 96'h1);
		wake_in <= wm;
		wlo(4);
		chk(96'({tiers.chip_por_n, tiers.chip_rst_nvlls_n}), 96'h1);
		chk(96'(reset_pin_en), 96'h0);
		wake_in <= 8'h00;
		pm_mode <= PM_RUN;
		wrel();
		chkst(8);
		rd(OFS_WFLG, 32'(wm));
		bus(1'b1, OFS_WFLG, 32'hff);
		rd(OFS_WFLG, 32'h0);
		$display("test wakeup done");
		srcs <= 7'h02;
		repeat (4000) @(posedge hclk);
		chk(96'(tiers.chip_n), 96'h1);
		wlo(200);
		srcs <= 7'h01;
		wrel();
		chkst(7);
		$display("test stop ack done");
		summarize();
	end
endmodule
